// [include/dbg_ctl_pkg.sv]
`default_nettype none
package dbg_ctl_pkg;
    // apb byte addresses of the debug control block
    localparam logic [7:0] ADDR_CONTROL  = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    // control register field positions
    localparam int CTL_MODE_BIT  = 7;
    localparam int CTL_BREAKPOINT_ENABLE_BIT_BIT = 6;
    localparam int CTL_ACK_BIT   = 5;
    localparam int CTL_RST_BIT   = 0;
    // status register field positions
    localparam int ST_DBG_BIT  = 7;
    localparam int ST_HALT_BIT = 6;
    localparam int ST_RP_BIT   = 5;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] BREAK_OPCODE  = 8'h00;
    localparam logic [7:0] ACK_CHAR      = 8'hFF;
    // interrupt event bits
    localparam int EV_BREAK = 0;
    localparam int EV_WATCH = 1;
    localparam int EV_RSTDN = 2;
    localparam int EV_W     = 3;
    // device reset pulse length
    localparam int RST_TIME_NS   = 200;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_CYCLES    = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RST_CNT_LAST = 8'(RST_CYCLES - 1);

    typedef enum logic [1:0] {RS_IDLE, RS_ACTIVE, RS_DONE} rst_state_t;

    typedef struct packed {
        logic [7:0]      control_q;
        logic [EV_W-1:0] irq_stat_q;
        logic [EV_W-1:0] irq_mask_q;
        rst_state_t      rst_state_q;
        logic [7:0]      rst_cnt_q;
        logic            sys_reset_q;
        logic            ack_valid_q;
        logic [7:0]      ack_data_q;
        logic            halt_core_q;
        logic            irq_q;
        logic [31:0]     prdata_q;
        logic            pready_q;
        logic            pslverr_q;
        logic [1:0]      halt_sync_q;
        logic [1:0]      rp_sync_q;
    } state_t;
endpackage : dbg_ctl_pkg
`default_nettype wire

// [hdl/debugger_control_status.sv]
// Summary of operation
// (RULE1) break opcode with breakpoints disabled acts as a no-operation.
// (RULE2) break opcode with breakpoints enabled sets the debug mode request bit.
// (RULE3) with acknowledge enabled, send FFH on every breakpoint or watchpoint; events in one cycle or while an FFH awaits ack_ready get one FFH.
// (RULE4) writing 1 to reset request resets device but not the debug unit.
// (RULE5) reset request bit clears itself when the reset sequence finishes.
// (RULE6) host writes zeros to reserved control bits.
// (RULE7) status bit 7 shows debug mode.
// (RULE8) status bit 6 shows halt mode.
// (RULE9) status register is read-only, resets to zero, bit 5 read protect.
// (RULE10) host access to memories, breakpoints and instructions goes through this unit.
// (RULE11) unit pairs with transmitter, receiver, auto-baud and this controller.
// (RULE12) core stays halted while debug mode request is set.
`timescale 1ns/1ps
`default_nettype none
module debugger_control_status
    import dbg_ctl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        opcode_valid,
    input  wire logic [7:0]  opcode,
    input  wire logic        watchpoint_hit,
    input  wire logic        halt_mode_in,
    input  wire logic        read_protect_in,
    input  wire logic        ack_ready,
    output logic             ack_valid,
    output logic      [7:0]  ack_data,
    output logic             sys_reset,
    output logic             halt_core,
    output logic             irq
);
    state_t s_q;
    state_t s_d;

    logic apb_wr;
    logic apb_rd;
    logic brk_hit;
    logic [EV_W-1:0] ev;
    logic [7:0] status_val;

    // reserved control field sits between the reset bit and the acknowledge enable
    localparam int CTL_RSV_LO = CTL_RST_BIT + 1;
    localparam int CTL_RSV_HI = CTL_ACK_BIT - 1;
    // device reset pulse length in cycles, minus the first one
    localparam int RST_LEN_M1 = RST_CYCLES - 1;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    always_comb begin
        s_d = s_q;
        apb_wr = psel && penable && pwrite;
        apb_rd = psel && penable && !pwrite;
        // break is decoded only when enabled; otherwise it falls through as a nop
        brk_hit = opcode_valid && hit(opcode, BREAK_OPCODE)
                  && s_q.control_q[CTL_BREAKPOINT_ENABLE_BIT_BIT];                    // [RULE1]
        status_val = STATUS_RESET;
        status_val[ST_DBG_BIT]  = s_q.control_q[CTL_MODE_BIT];       // [RULE7]
        status_val[ST_HALT_BIT] = s_q.halt_sync_q[1];                // [RULE8]
        status_val[ST_RP_BIT]   = s_q.rp_sync_q[1];                  // [RULE9]
        ev = '0;
        ev[EV_BREAK] = brk_hit;
        ev[EV_WATCH] = watchpoint_hit;
        ev[EV_RSTDN] = (s_q.rst_state_q == RS_DONE);

        s_d.halt_sync_q = {s_q.halt_sync_q[0], halt_mode_in};
        s_d.rp_sync_q   = {s_q.rp_sync_q[0], read_protect_in};

        // apb answers in the access cycle itself, one-cycle ready pulse
        s_d.pready_q  = psel && !penable;
        s_d.pslverr_q = 1'b0;
        if (apb_wr && s_q.pready_q) begin
            if (hit(paddr, ADDR_CONTROL)) begin
                s_d.control_q = pwdata[7:0];
                // reserved bits are kept at zero even if host misbehaves
                s_d.control_q[CTL_RSV_HI:CTL_RSV_LO] = '0;           // [RULE6]
                // a write of 0 to the reset bit never cancels a running reset
                s_d.control_q[CTL_RST_BIT] = s_q.control_q[CTL_RST_BIT]
                                             | pwdata[CTL_RST_BIT];   // [RULE4]
            end else if (hit(paddr, ADDR_IRQ_MASK)) begin
                s_d.irq_mask_q = pwdata[EV_W-1:0];
            end else if (!hit(paddr, ADDR_STATUS) && !hit(paddr, ADDR_IRQ_STAT)) begin
                s_d.pslverr_q = 1'b0;
            end
        end
        s_d.prdata_q = '0;
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, ADDR_CONTROL)) begin
                s_d.prdata_q[7:0] = s_q.control_q;
            end else if (hit(paddr, ADDR_STATUS)) begin
                s_d.prdata_q[7:0] = status_val;                       // [RULE9]
            end else if (hit(paddr, ADDR_IRQ_STAT)) begin
                s_d.prdata_q[EV_W-1:0] = s_q.irq_stat_q;
            end else if (hit(paddr, ADDR_IRQ_MASK)) begin
                s_d.prdata_q[EV_W-1:0] = s_q.irq_mask_q;
            end else begin
                s_d.prdata_q = '0;
            end
        end
        // read clears status, a new event in the same cycle wins
        if (apb_rd && s_q.pready_q && hit(paddr, ADDR_IRQ_STAT)) begin
            s_d.irq_stat_q = '0;
        end
        s_d.irq_stat_q = s_d.irq_stat_q | ev;

        if (brk_hit) begin
            s_d.control_q[CTL_MODE_BIT] = 1'b1;                       // [RULE2] [RULE10]
        end

        // acknowledge character towards the serial transmitter [RULE11]
        if (s_q.ack_valid_q && ack_ready) begin
            s_d.ack_valid_q = 1'b0;
        end
        if ((brk_hit || watchpoint_hit) && s_q.control_q[CTL_ACK_BIT]) begin
            s_d.ack_valid_q = 1'b1;                                   // [RULE3]
            s_d.ack_data_q  = ACK_CHAR;                               // [RULE3]
        end

        // device reset sequencer; only the core is reset, not this unit
        case (s_q.rst_state_q)
            RS_IDLE: begin
                s_d.sys_reset_q = 1'b0;
                if (s_q.control_q[CTL_RST_BIT]) begin
                    s_d.rst_state_q = RS_ACTIVE;
                    s_d.rst_cnt_q   = '0;
                    s_d.sys_reset_q = 1'b1;                           // [RULE4]
                end
            end
            RS_ACTIVE: begin
                s_d.rst_cnt_q = s_q.rst_cnt_q + 8'h01;
                if (s_q.rst_cnt_q == RST_CNT_LAST) begin
                    s_d.sys_reset_q = 1'b0;
                    s_d.rst_state_q = RS_DONE;
                end
            end
            RS_DONE: begin
                s_d.control_q[CTL_RST_BIT] = 1'b0;                    // [RULE5]
                s_d.rst_state_q = RS_IDLE;
            end
            default: begin
                s_d.rst_state_q = RS_IDLE;
            end
        endcase

        s_d.halt_core_q = s_d.control_q[CTL_MODE_BIT];                // [RULE12]
        s_d.irq_q = |(s_d.irq_stat_q & s_d.irq_mask_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata    = s_q.prdata_q;
    assign pready    = s_q.pready_q;
    assign pslverr   = s_q.pslverr_q;
    assign ack_valid = s_q.ack_valid_q;
    assign ack_data  = s_q.ack_data_q;
    assign sys_reset = s_q.sys_reset_q;
    assign halt_core = s_q.halt_core_q;
    assign irq       = s_q.irq_q;

    // checks
    property p_nop_break;
        @(posedge pclk) disable iff (!presetn)
        (opcode_valid && opcode == BREAK_OPCODE && !s_q.control_q[CTL_BREAKPOINT_ENABLE_BIT_BIT]
         && !s_q.control_q[CTL_MODE_BIT] && !(apb_wr && s_q.pready_q))
        |=> !s_q.control_q[CTL_MODE_BIT];
    endproperty
    a_nop_break: assert property (p_nop_break) else $error("break acted while disabled"); // [RULE1]

    property p_break_sets;
        @(posedge pclk) disable iff (!presetn)
        brk_hit |=> s_q.control_q[CTL_MODE_BIT] ##1 halt_core;
    endproperty
    a_break_sets: assert property (p_break_sets) else $error("break did not request debug"); // [RULE2]

    property p_ack;
        @(posedge pclk) disable iff (!presetn)
        ((brk_hit || watchpoint_hit) && s_q.control_q[CTL_ACK_BIT]) |=> ack_valid && ack_data == ACK_CHAR;
    endproperty
    a_ack: assert property (p_ack) else $error("ack character missing"); // [RULE3]

    property p_no_ack;
        @(posedge pclk) disable iff (!presetn)
        (!ack_valid && !s_q.control_q[CTL_ACK_BIT]) |=> !ack_valid;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("ack sent while disabled"); // [RULE3]

    sequence s_rst_req;
        s_q.rst_state_q == RS_IDLE && s_q.control_q[CTL_RST_BIT];
    endsequence
    property p_rst_pulse;
        @(posedge pclk) disable iff (!presetn)
        s_rst_req |=> sys_reset [*8];
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("device reset too short"); // [RULE4]

    property p_rst_clear;
        @(posedge pclk) disable iff (!presetn)
        s_rst_req |-> ##[1:40] !s_q.control_q[CTL_RST_BIT];
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset bit not cleared"); // [RULE5]

    property p_dbg_flag;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == ADDR_STATUS)
        |=> prdata[ST_DBG_BIT] == $past(s_q.control_q[CTL_MODE_BIT]);
    endproperty
    a_dbg_flag: assert property (p_dbg_flag) else $error("debug flag wrong"); // [RULE7]

    property p_halt_flag;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == ADDR_STATUS)
        |=> prdata[ST_HALT_BIT] == $past(s_q.halt_sync_q[1]);
    endproperty
    a_halt_flag: assert property (p_halt_flag) else $error("halt flag wrong"); // [RULE8]

    property p_status_low;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == ADDR_STATUS) |=> prdata[ST_RP_BIT-1:0] == '0;
    endproperty
    a_status_low: assert property (p_status_low) else $error("reserved status bits set"); // [RULE9]

    property p_halt_core;
        @(posedge pclk) disable iff (!presetn)
        s_q.control_q[CTL_MODE_BIT] && $stable(s_q.control_q[CTL_MODE_BIT]) |-> halt_core;
    endproperty
    a_halt_core: assert property (p_halt_core) else $error("core not halted"); // [RULE12]

    property p_rsv_zero;
        @(posedge pclk) disable iff (!presetn)
        s_q.control_q[CTL_RSV_HI:CTL_RSV_LO] == '0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved control bits set"); // [RULE6]

    property p_mode_hold;
        @(posedge pclk) disable iff (!presetn)
        (s_q.control_q[CTL_MODE_BIT] && !(apb_wr && s_q.pready_q && paddr == ADDR_CONTROL))
        |=> s_q.control_q[CTL_MODE_BIT] && halt_core;
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("debug request dropped by itself"); // [RULE12]

    property p_rst_idle;
        @(posedge pclk) disable iff (!presetn)
        (s_q.rst_state_q == RS_IDLE && !s_q.control_q[CTL_RST_BIT]) |=> !sys_reset;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("device reset without request"); // [RULE4]

    sequence s_rst_hold;
        ##RST_LEN_M1 sys_reset ##1 !sys_reset;
    endsequence
    property p_rst_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(sys_reset) |-> s_rst_hold;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("device reset length wrong"); // [RULE4]

    sequence s_rst_finish;
        s_q.rst_state_q == RS_DONE ##1 (!s_q.control_q[CTL_RST_BIT] && s_q.irq_stat_q[EV_RSTDN]);
    endsequence
    property p_rst_finish;
        @(posedge pclk) disable iff (!presetn)
        $fell(sys_reset) |-> s_rst_finish;
    endproperty
    a_rst_finish: assert property (p_rst_finish) else $error("reset finish not reported"); // [RULE5]

    property p_ack_hold;
        @(posedge pclk) disable iff (!presetn)
        (ack_valid && !ack_ready) |=> ack_valid && ack_data == ACK_CHAR;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack character dropped"); // [RULE3]

    property p_ack_cause;
        @(posedge pclk) disable iff (!presetn)
        (!ack_valid && !((brk_hit || watchpoint_hit) && s_q.control_q[CTL_ACK_BIT])) |=> !ack_valid;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack character without event"); // [RULE3]

    property p_halt_sync;
        @(posedge pclk) disable iff (!presetn)
        halt_mode_in |-> ##2 s_q.halt_sync_q[1];
    endproperty
    a_halt_sync: assert property (p_halt_sync) else $error("halt pin not seen"); // [RULE8]

    property p_rp_sync;
        @(posedge pclk) disable iff (!presetn)
        read_protect_in |-> ##2 s_q.rp_sync_q[1];
    endproperty
    a_rp_sync: assert property (p_rp_sync) else $error("read protect pin not seen"); // [RULE9]

    property p_rp_flag;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == ADDR_STATUS)
        |=> prdata[ST_RP_BIT] == $past(s_q.rp_sync_q[1]);
    endproperty
    a_rp_flag: assert property (p_rp_flag) else $error("read protect flag wrong"); // [RULE9]
endmodule : debugger_control_status
`default_nettype wire

// [tb/ack_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ack_host_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ack_valid,
    input  wire logic [7:0] ack_data,
    input  wire logic       slow,
    output logic            ack_ready,
    output int              rx_count,
    output logic      [7:0] rx_last
);
    logic [1:0] div_q;
    // slow mode takes a character only every fourth cycle
    assign ack_ready = !slow || (div_q == 2'h3);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q    <= 2'h0;
            rx_count <= 0;
            rx_last  <= 8'h00;
        end else begin
            div_q <= div_q + 2'h1;
            if (ack_valid && ack_ready) begin
                rx_count <= rx_count + 1;
                rx_last  <= ack_data;
            end
        end
    end
endmodule : ack_host_model
`default_nettype wire

// [tb/debugger_control_status_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module debugger_control_status_tb;
    import dbg_ctl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, opcode_valid, watchpoint_hit;
    logic halt_mode_in, read_protect_in, ack_ready, ack_valid, sys_reset, halt_core, irq, slow;
    logic [7:0]  paddr, opcode, ack_data, rx_last;
    logic [31:0] pwdata, prdata, r;
    int          err_count, tests_run, rx_count, n;

    debugger_control_status i_debugger_control_status (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .opcode_valid(opcode_valid), .opcode(opcode),
        .watchpoint_hit(watchpoint_hit), .halt_mode_in(halt_mode_in), .read_protect_in(read_protect_in),
        .ack_ready(ack_ready), .ack_valid(ack_valid), .ack_data(ack_data), .sys_reset(sys_reset),
        .halt_core(halt_core), .irq(irq));
    ack_host_model i_ack_host_model (.pclk(pclk), .presetn(presetn), .ack_valid(ack_valid),
        .ack_data(ack_data), .slow(slow), .ack_ready(ack_ready), .rx_count(rx_count), .rx_last(rx_last));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // master holds the request until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle cycle so back-to-back calls never drive psel twice in one step
        @(posedge pclk);
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask : rd

    task pulse_op(input logic [7:0] o, input logic wp);
        opcode_valid   <= !wp;
        opcode         <= o;
        watchpoint_hit <= wp;
        @(posedge pclk);
        opcode_valid   <= 1'b0;
        watchpoint_hit <= 1'b0;
        repeat (12) @(posedge pclk);
    endtask : pulse_op

    task t_reset_values;
        rd(ADDR_CONTROL, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_IRQ_STAT, 32'h0);
        rd(ADDR_IRQ_MASK, 32'h0);
        rd(8'h40, 32'h0);
        chk(pslverr, 1'b0);
    endtask : t_reset_values

    task t_break_disabled;
        pulse_op(BREAK_OPCODE, 1'b0);
        rd(ADDR_CONTROL, 32'h0);
        chk(halt_core, 1'b0);
        chk(rx_count, 0);
        apb(1'b1, ADDR_CONTROL, 32'h20);
        pulse_op(BREAK_OPCODE, 1'b0);
        rd(ADDR_CONTROL, 32'h20);
        chk(rx_count, 0);
        rd(ADDR_IRQ_STAT, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h0);
    endtask : t_break_disabled

    task t_break_enabled;
        apb(1'b1, ADDR_IRQ_MASK, 32'h7);
        apb(1'b1, ADDR_CONTROL, 32'h60); // reserved bits left zero
        pulse_op(8'h01, 1'b0);
        rd(ADDR_CONTROL, 32'h60);
        pulse_op(BREAK_OPCODE, 1'b0);
        rd(ADDR_CONTROL, 32'hE0);
        chk(halt_core, 1'b1);
        rd(ADDR_STATUS, 32'h80);
        chk(rx_count, 1);
        chk(rx_last, ACK_CHAR);
        chk(irq, 1'b1);
        rd(ADDR_IRQ_STAT, 32'h1);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        slow <= 1'b1;
        pulse_op(8'h00, 1'b1);
        chk(rx_count, 2);
        apb(1'b1, ADDR_CONTROL, 32'h40);
        pulse_op(8'h00, 1'b1);
        chk(rx_count, 2);
        chk(halt_core, 1'b0);
        rd(ADDR_STATUS, 32'h00);
        rd(ADDR_IRQ_STAT, 32'h2);
    endtask : t_break_enabled

    task t_status_flags;
        halt_mode_in    <= 1'b1;
        read_protect_in <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(ADDR_STATUS, 32'h60);
        apb(1'b1, ADDR_STATUS, 32'hFF);
        rd(ADDR_STATUS, 32'h60);
        halt_mode_in    <= 1'b0;
        read_protect_in <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(ADDR_STATUS, 32'h00);
    endtask : t_status_flags

    task t_device_reset;
        apb(1'b1, ADDR_CONTROL, 32'h40);
        repeat (3) @(posedge pclk);
        chk(sys_reset, 1'b0);
        apb(1'b1, ADDR_CONTROL, 32'h41);
        n = 0;
        while (sys_reset !== 1'b1 && n < 5) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (sys_reset === 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk(n, RST_CYCLES);
        repeat (4) @(posedge pclk);
        rd(ADDR_CONTROL, 32'h40);
        rd(ADDR_IRQ_STAT, 32'h4);
    endtask : t_device_reset

    initial begin
        {presetn, psel, penable, pwrite, opcode_valid, watchpoint_hit, halt_mode_in, read_protect_in} = '0;
        {paddr, opcode, pwdata} = '0;
        slow      = 1'b0;
        err_count = 0;
        tests_run = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
        t_break_disabled();
        t_break_enabled();
        t_status_flags();
        t_device_reset();
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        give_verdict();
    end
endmodule : debugger_control_status_tb
`default_nettype wire
